// *** rtl/fault_response_pkg.sv ***
// constants shared by the fault response logic
// Behaviour
// [RULE1] Undervoltage action 00: channel keeps running; only the status is reported.
// [RULE2] Action 01: keep running for the delay, then act per retry field if fault persists.
// [RULE3] Action 10: disable the output on detection, then follow the retry field.
// [RULE4] Writing 11 to the undervoltage action field is refused and flags CML.
// [RULE5] Retry 000 to 110: stay off until faults cleared, commanded off, or bias lost.
// [RULE6] Retry 111: restart without limit until commanded off or otherwise stopped.
// [RULE7] Restart spacing comes from the retry interval setting, not the action byte.
// [RULE8] Delay field counts 10 us units, used by the deglitched action only.
// [RULE9] Every action sets its status bit and raises ALERT unless masked.
// [RULE10] Status bits clear only by clear command, off-then-on, or bias loss.
// [RULE11] Turn-on timeout sets none-of-above, VOUT word bit, timeout bit, and ALERT.
// [RULE12] Turn-on timeout action value zero disables that action.
// [RULE13] The turn-on timeout action command carries exactly one data byte.
// [RULE14] Overcurrent action byte: read/write at code 47h, default 00h.
// [RULE15] Undervoltage fault sets the VOUT word bit and undervoltage status bit.
// [RULE16] Undervoltage detection is suppressed when inactive or ramping.
// [RULE17] Deglitch count starts at detection and is abandoned if the fault leaves.
package fault_response_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_US       = 10;
  localparam int TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam logic [8:0] TICK_LAST = 9'(TICK_CYCLES - 1);

  localparam logic [7:0] CMD_OPERATION  = 8'h01;
  localparam logic [7:0] CMD_CLEAR      = 8'h03;
  localparam logic [7:0] CMD_UV_RESP    = 8'h45;
  localparam logic [7:0] CMD_OC_RESP    = 8'h47;
  localparam logic [7:0] CMD_TON_RESP   = 8'h63;
  localparam logic [7:0] CMD_ST_BYTE    = 8'h78;
  localparam logic [7:0] CMD_ST_WORD    = 8'h79;
  localparam logic [7:0] CMD_ST_VOUT    = 8'h7A;
  localparam logic [7:0] CMD_RETRY_INT  = 8'hF0;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hF1;

  localparam logic [7:0] OC_RESP_RST    = 8'h00;
  localparam logic [7:0] UV_RESP_RST    = 8'h80;
  localparam logic [7:0] TON_RESP_RST   = 8'h80;
  localparam logic [7:0] RETRY_INT_RST  = 8'h0A;
  localparam logic [7:0] OPERATION_RST  = 8'h80;
  localparam logic [7:0] ALERT_MASK_RST = 8'h00;

  localparam int RESP_HI  = 7;
  localparam int RESP_LO  = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_DEGLITCH = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_BAD      = 2'h3;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  localparam int OP_ON_BIT = 7;
  localparam int SB_NONE   = 0;
  localparam int SB_CML    = 1;
  localparam int SV_TON    = 2;
  localparam int SV_UV     = 4;
  localparam int SW_VOUT   = 15;
  localparam int MASK_UV   = 0;
  localparam int MASK_TON  = 1;
  localparam int MASK_CML  = 2;
endpackage

// *** rtl/fault_action_if.sv ***
// carrier between the top and one fault action unit
`timescale 1ns/1ps
`default_nettype none
interface fault_action_if;
  logic [7:0] respByte;
  logic       respEnable;
  logic       fault;
  logic       tick;
  logic       clear;
  logic [7:0] retryInterval;
  logic       faultEvent;
  logic       outputOff;
  modport unit (input respByte, respEnable, fault, tick, clear, retryInterval,
                output faultEvent, outputOff);
  modport ctrl (output respByte, respEnable, fault, tick, clear, retryInterval,
                input faultEvent, outputOff);
endinterface
`default_nettype wire

// *** rtl/fault_action_unit.sv ***
// one fault's action sequencer: ignore, deglitch, shutdown and retry
`timescale 1ns/1ps
`default_nettype none
module fault_action_unit (
  input wire logic     sys_clk,
  input wire logic     rst_n,
  fault_action_if.unit act
);
  import fault_response_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DEGLITCH, ST_OFF, ST_RETRY} act_state_e;
  act_state_e  state_reg, state_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic        faultPrev_reg;

  wire [1:0] resp         = act.respByte[RESP_HI:RESP_LO];
  wire       retryForever = act.respByte[RETRY_HI:RETRY_LO] == RETRY_FOREVER;
  wire [7:0] delayUnits   = {5'h00, act.respByte[DELAY_HI:DELAY_LO]};
  wire       faultRise    = act.fault & ~faultPrev_reg;
  wire       cntZero      = cnt_reg == 8'h00;

  assign act.faultEvent = faultRise;
  assign act.outputOff  = (state_reg == ST_OFF) || (state_reg == ST_RETRY);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // respEnable low leaves the fault reported but without action, see [RULE12]
        if (faultRise && act.respEnable) begin
          unique case (resp)
            RESP_DEGLITCH: begin // see [RULE17]
              state_next = ST_DEGLITCH;
              cnt_next   = delayUnits; // see [RULE8]
            end
            RESP_SHUTDOWN: state_next = ST_OFF; // see [RULE3]
            RESP_IGNORE, RESP_BAD: state_next = ST_IDLE; // see [RULE1]
          endcase
        end
      end
      ST_DEGLITCH: begin
        if (!act.fault) begin
          state_next = ST_IDLE; // see [RULE17]
        end else if (cntZero) begin
          state_next = ST_OFF; // see [RULE2]
        end else if (act.tick) begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ST_OFF: begin
        if (retryForever) begin // see [RULE6]
          state_next = ST_RETRY;
          cnt_next   = act.retryInterval; // see [RULE7]
        end
      end
      ST_RETRY: begin
        if (cntZero) begin
          state_next = ST_IDLE;
        end else if (act.tick) begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
    endcase
    // only clear or off leaves a latched shutdown, see [RULE5]
    if (act.clear) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 8'h00;
      faultPrev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      faultPrev_reg <= act.fault;
    end
  end

  property p_ignore;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && resp == RESP_IGNORE && !act.clear) |=> !act.outputOff;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore action disabled output"); // see [RULE1]

  property p_deglitch_expire;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_DEGLITCH && act.fault && cntZero && !act.clear) |=> act.outputOff;
  endproperty
  a_deglitch_expire: assert property (p_deglitch_expire) else $error("no shutdown after delay"); // see [RULE2]

  property p_hard_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && faultRise && act.respEnable && resp == RESP_SHUTDOWN
     && !act.clear) |=> act.outputOff;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("shutdown action missed"); // see [RULE3]

  property p_latched;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_OFF && !retryForever && !act.clear) |=> state_reg == ST_OFF;
  endproperty
  a_latched: assert property (p_latched) else $error("restart without retry"); // see [RULE5]

  property p_retry_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_OFF && retryForever && !act.clear)
      |=> state_reg == ST_RETRY && cnt_reg == $past(act.retryInterval);
  endproperty
  a_retry_load: assert property (p_retry_load) else $error("retry interval not used"); // see [RULE7]

  property p_abandon;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_DEGLITCH && !act.fault) |=> state_reg == ST_IDLE && !act.outputOff;
  endproperty
  a_abandon: assert property (p_abandon) else $error("glitch not abandoned"); // see [RULE17]

  c_deglitch_off: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_DEGLITCH ##1 state_reg == ST_OFF);
  c_retry_restart: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_RETRY ##1 state_reg == ST_IDLE);
endmodule
`default_nettype wire

// *** rtl/fault_response_top.sv ***
// fault status, alert and response configuration for one output channel
`timescale 1ns/1ps
`default_nettype none
module fault_response_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        channelRunPin,
  input  wire logic        uvComparator,
  input  wire logic        tonMaxExpired,
  input  wire logic        channelActive,
  input  wire logic        rampActive,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [1:0]  cmdLen,
  input  wire logic [7:0]  cmdData,
  output logic      [15:0] rdData,
  output logic             rdValid,
  output logic             channelEnable,
  output logic             alert,
  output logic      [7:0]  ocFaultAction
);
  import fault_response_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and time base
  // ----------------------------------------------------------------
  logic [2:0] runSync_reg, uvSync_reg;
  logic       runLevel_reg, uvLevel_reg, onPrev_reg;
  logic [8:0] tickCnt_reg;
  logic [7:0] uvResp_reg, ocResp_reg, tonResp_reg, retryInt_reg, operation_reg, mask_reg;
  logic       stUv_reg, stTon_reg, stCml_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      runSync_reg  <= 3'h0;
      uvSync_reg   <= 3'h0;
      runLevel_reg <= 1'b0;
      uvLevel_reg  <= 1'b0;
    end else begin
      runSync_reg <= {runSync_reg[1:0], channelRunPin};
      uvSync_reg  <= {uvSync_reg[1:0], uvComparator};
      if (runSync_reg[1] == runSync_reg[2]) begin
        runLevel_reg <= runSync_reg[2];
      end
      if (uvSync_reg[1] == uvSync_reg[2]) begin
        uvLevel_reg <= uvSync_reg[2];
      end
    end
  end

  wire tick        = tickCnt_reg == TICK_LAST;
  wire commandedOn = runLevel_reg & operation_reg[OP_ON_BIT];
  wire onRise      = commandedOn & ~onPrev_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_reg <= 9'h000;
      onPrev_reg  <= 1'b0;
    end else begin
      tickCnt_reg <= tick ? 9'h000 : tickCnt_reg + 9'h001;
      onPrev_reg  <= commandedOn;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire wrCmd     = cmdValid & cmdWrite;
  wire rdCmd     = cmdValid & ~cmdWrite;
  wire lenOne    = cmdLen == 2'h1;
  wire isUv      = cmdCode == CMD_UV_RESP;
  wire isOc      = cmdCode == CMD_OC_RESP;
  wire isTon     = cmdCode == CMD_TON_RESP;
  wire isRetry   = cmdCode == CMD_RETRY_INT;
  wire isOper    = cmdCode == CMD_OPERATION;
  wire isMask    = cmdCode == CMD_ALERT_MASK;
  wire isClear   = cmdCode == CMD_CLEAR;
  wire isStatus  = (cmdCode == CMD_ST_BYTE) | (cmdCode == CMD_ST_WORD) | (cmdCode == CMD_ST_VOUT);
  wire isByteReg = isUv | isOc | isTon | isRetry | isOper | isMask;
  wire uvBadResp = cmdData[RESP_HI:RESP_LO] == RESP_BAD;
  wire wrByteOk  = wrCmd & isByteReg & lenOne & ~(isUv & uvBadResp); // see [RULE4] [RULE13]
  wire clearCmd  = wrCmd & isClear & (cmdLen == 2'h0);
  wire cmlEvent  = (wrCmd & isByteReg & ~wrByteOk)
                 | (wrCmd & isClear & ~clearCmd)
                 | (wrCmd & ~isByteReg & ~isClear)
                 | (rdCmd & ~isByteReg & ~isStatus);
  // faults also release on the next off-then-on
  wire unitClear = clearCmd | ~commandedOn;
  wire statClear = clearCmd | onRise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uvResp_reg    <= UV_RESP_RST;
      ocResp_reg    <= OC_RESP_RST; // see [RULE14]
      tonResp_reg   <= TON_RESP_RST;
      retryInt_reg  <= RETRY_INT_RST;
      operation_reg <= OPERATION_RST;
      mask_reg      <= ALERT_MASK_RST;
    end else if (wrByteOk) begin
      if (isUv) uvResp_reg <= cmdData;
      if (isOc) ocResp_reg <= cmdData; // see [RULE14]
      if (isTon) tonResp_reg <= cmdData; // see [RULE13]
      if (isRetry) retryInt_reg <= cmdData;
      if (isOper) operation_reg <= cmdData;
      if (isMask) mask_reg <= cmdData;
    end
  end

  // ----------------------------------------------------------------
  // fault action units
  // ----------------------------------------------------------------
  fault_action_if uvIf ();
  fault_action_if tonIf ();

  // qualified detection keeps ramps from tripping the channel, see [RULE16]
  wire uvQualified = uvLevel_reg & channelActive & ~rampActive;

  assign uvIf.respByte       = uvResp_reg;
  assign uvIf.respEnable     = 1'b1;
  assign uvIf.fault          = uvQualified;
  assign uvIf.tick           = tick;
  assign uvIf.clear          = unitClear;
  assign uvIf.retryInterval  = retryInt_reg;
  assign tonIf.respByte      = tonResp_reg;
  assign tonIf.respEnable    = tonResp_reg != 8'h00; // see [RULE12]
  assign tonIf.fault         = tonMaxExpired;
  assign tonIf.tick          = tick;
  assign tonIf.clear         = unitClear;
  assign tonIf.retryInterval = retryInt_reg;

  fault_action_unit uvUnit (.sys_clk(sys_clk), .rst_n(rst_n), .act(uvIf.unit));
  fault_action_unit tonUnit (.sys_clk(sys_clk), .rst_n(rst_n), .act(tonIf.unit));

  // ----------------------------------------------------------------
  // sticky status, alert, read back
  // ----------------------------------------------------------------
  wire [7:0]  statusByte = {6'h00, stCml_reg, stTon_reg} << 0;
  wire [7:0]  statusVout = {3'h0, stUv_reg, 1'b0, stTon_reg, 2'h0};
  wire [15:0] statusWord = {stUv_reg | stTon_reg, 7'h00, statusByte};
  wire alertNext = (stUv_reg & ~mask_reg[MASK_UV]) | (stTon_reg & ~mask_reg[MASK_TON])
                 | (stCml_reg & ~mask_reg[MASK_CML]);
  wire [7:0] byteRead = isUv ? uvResp_reg : isOc ? ocResp_reg : isTon ? tonResp_reg :
                        isRetry ? retryInt_reg : isOper ? operation_reg : mask_reg;
  wire [15:0] readMux = (cmdCode == CMD_ST_WORD) ? statusWord :
                        (cmdCode == CMD_ST_BYTE) ? {8'h00, statusByte} :
                        (cmdCode == CMD_ST_VOUT) ? {8'h00, statusVout} :
                        isByteReg ? {8'h00, byteRead} : 16'h0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stUv_reg      <= 1'b0;
      stTon_reg     <= 1'b0;
      stCml_reg     <= 1'b0;
      alert         <= 1'b0;
      rdData        <= 16'h0000;
      rdValid       <= 1'b0;
      channelEnable <= 1'b0;
    end else begin
      // set beats clear in the same cycle, see [RULE9] [RULE10]
      stUv_reg      <= uvIf.faultEvent | (stUv_reg & ~statClear); // see [RULE15]
      stTon_reg     <= tonIf.faultEvent | (stTon_reg & ~statClear); // see [RULE11]
      stCml_reg     <= cmlEvent | (stCml_reg & ~statClear); // see [RULE4]
      alert         <= alertNext; // see [RULE9]
      rdValid       <= rdCmd;
      rdData        <= rdCmd ? readMux : rdData;
      channelEnable <= commandedOn & ~uvIf.outputOff & ~tonIf.outputOff; // see [RULE5]
    end
  end

  assign ocFaultAction = ocResp_reg;

  property p_uv_bad_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (wrCmd && isUv && uvBadResp) |=> stCml_reg && $stable(uvResp_reg);
  endproperty
  a_uv_bad_write: assert property (p_uv_bad_write) else $error("11 write not refused"); // see [RULE4]

  property p_one_byte;
    @(posedge sys_clk) disable iff (!rst_n)
    (wrCmd && isTon && !lenOne) |=> stCml_reg && $stable(tonResp_reg);
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("bad length accepted"); // see [RULE13]

  property p_uv_status;
    @(posedge sys_clk) disable iff (!rst_n)
    uvIf.faultEvent |=> stUv_reg && statusWord[SW_VOUT] && statusVout[SV_UV];
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("uv status not set"); // see [RULE15]

  property p_ton_status;
    @(posedge sys_clk) disable iff (!rst_n)
    tonIf.faultEvent |=> statusByte[SB_NONE] && statusWord[SW_VOUT] && statusVout[SV_TON];
  endproperty
  a_ton_status: assert property (p_ton_status) else $error("timeout status not set"); // see [RULE11]

  property p_alert;
    @(posedge sys_clk) disable iff (!rst_n)
    (stUv_reg && !mask_reg[MASK_UV]) |=> alert;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised"); // see [RULE9]

  property p_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
    (stTon_reg && !statClear) |=> stTon_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost"); // see [RULE10]

  property p_ton_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(tonIf.outputOff) |-> $past(tonResp_reg) != 8'h00;
  endproperty
  a_ton_zero: assert property (p_ton_zero) else $error("zero action shut down"); // see [RULE12]

  property p_uv_masked;
    @(posedge sys_clk) disable iff (!rst_n)
    (!channelActive || rampActive) ##1 (!channelActive || rampActive) |-> !uvIf.faultEvent;
  endproperty
  a_uv_masked: assert property (p_uv_masked) else $error("uv seen while masked"); // see [RULE16]

  property p_oc_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (rdCmd && isOc) |=> rdValid && rdData == {8'h00, $past(ocResp_reg)};
  endproperty
  a_oc_read: assert property (p_oc_read) else $error("oc action read wrong"); // see [RULE14]

  c_cml: cover property (@(posedge sys_clk) disable iff (!rst_n) cmlEvent ##1 alert);
  c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) stUv_reg ##1 clearCmd);
endmodule
`default_nettype wire

// *** verif/pmbus_host_model.sv ***
// host side model that issues commands to the fault response block
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] rdData,
  input  wire logic        rdValid,
  output var  logic        cmdValid,
  output var  logic        cmdWrite,
  output var  logic [7:0]  cmdCode,
  output var  logic [1:0]  cmdLen,
  output var  logic [7:0]  cmdData
);
  // ----------------------------------------
  // command issue, inputs move on falling edges
  // ----------------------------------------
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdLen   = 2'h0;
    cmdData  = 8'h00;
  end

  task automatic issue(input logic wrEn, input logic [7:0] code, input logic [1:0] len,
                       input logic [7:0] data);
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdWrite = wrEn;
    cmdCode  = code;
    cmdLen   = len;
    cmdData  = data;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    // released bus shows the inverse so a stale byte never looks valid
    cmdData  = ~data;
  endtask

  task automatic wr_byte(input logic [7:0] code, input logic [7:0] data);
    issue(1'b1, code, 2'h1, data);
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] d, output logic v);
    issue(1'b0, code, 2'h0, 8'h00);
    // rdValid stands only in the cycle after the request edge
    v = rdValid;
    d = rdData;
  endtask
endmodule
`default_nettype wire

// *** verif/output_fault_response_logic_tb.sv ***
// self-checking bench for the output fault response block
`timescale 1ns/1ps
`default_nettype none
module output_fault_response_logic_tb;
  import fault_response_pkg::*;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;

  logic        sys_clk;
  logic        rst_n;
  logic        channelRunPin;
  logic        uvComparator;
  logic        tonMaxExpired;
  logic        channelActive;
  logic        rampActive;
  logic        cmdValid;
  logic        cmdWrite;
  logic [7:0]  cmdCode;
  logic [1:0]  cmdLen;
  logic [7:0]  cmdData;
  logic [15:0] rdData;
  logic        rdValid;
  logic        channelEnable;
  logic        alert;
  logic [7:0]  ocFaultAction;
  int          fails = 0;
  int          n_tests = 0;
  int          n;
  row_s        rows [6] = '{'{CMD_OC_RESP, 8'h5A, 8'h5A}, '{CMD_OC_RESP, 8'h00, 8'h00},
                            '{CMD_UV_RESP, 8'h7F, 8'h7F}, '{CMD_TON_RESP, 8'h00, 8'h00},
                            '{CMD_RETRY_INT, 8'h02, 8'h02}, '{CMD_ALERT_MASK, 8'h00, 8'h00}};

  fault_response_top i_fault_response_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .channelRunPin(channelRunPin),
    .uvComparator(uvComparator), .tonMaxExpired(tonMaxExpired),
    .channelActive(channelActive), .rampActive(rampActive), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdLen(cmdLen), .cmdData(cmdData),
    .rdData(rdData), .rdValid(rdValid), .channelEnable(channelEnable), .alert(alert),
    .ocFaultAction(ocFaultAction)
  );

  pmbus_host_model i_pmbus_host_model (
    .sys_clk(sys_clk), .rdData(rdData), .rdValid(rdValid), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdLen(cmdLen), .cmdData(cmdData)
  );

  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  // bounded wait for the enable level; n keeps the cycles it took
  task automatic wait_en(input logic lvl, input int lim);
    n = 0;
    while (channelEnable !== lvl) begin
      if (n == lim) begin
        fails++;
        $display("mismatch at %0t: enable wait ran out", $time);
        tally_and_finish;
      end
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    i_pmbus_host_model.wr_byte(code, data);
  endtask

  task automatic clr;
    i_pmbus_host_model.issue(1'b1, CMD_CLEAR, 2'h0, 8'h00);
  endtask

  task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    i_pmbus_host_model.rd(code, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask

  task automatic uv(input logic lvl, input int k);
    uvComparator = lvl;
    cyc(k);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    channelRunPin = 1'b1;
    uvComparator = 1'b0;
    tonMaxExpired = 1'b0;
    channelActive = 1'b1;
    rampActive = 1'b0;
    cyc(4);
    check({8'h00, ocFaultAction}, {8'h00, OC_RESP_RST});
    check({13'h0000, rdValid, alert, channelEnable}, 16'h0000);
    rst_n = 1'b1;
    wait_en(1'b1, 20);
    rdchk(CMD_OC_RESP, 16'h0000);
    $display("test reset finished");
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].code, rows[i].wdata);
      rdchk(rows[i].code, {8'h00, rows[i].exp});
      if (rows[i].code == CMD_OC_RESP)
        check({8'h00, ocFaultAction}, {8'h00, rows[i].exp});
    end
    $display("test register rows finished");
    wr(CMD_UV_RESP, 8'hC0);
    rdchk(CMD_UV_RESP, 16'h007F);
    rdchk(CMD_ST_BYTE, 16'h0002);
    check({15'h0000, alert}, 16'h0001);
    clr;
    rdchk(CMD_ST_BYTE, 16'h0000);
    i_pmbus_host_model.issue(1'b1, CMD_TON_RESP, 2'h2, 8'h55);
    rdchk(CMD_TON_RESP, 16'h0000);
    rdchk(CMD_ST_BYTE, 16'h0002);
    clr;
    $display("test refused writes finished");
    wr(CMD_UV_RESP, 8'h00);
    // pass 0 masks by the ramp, pass 1 by an inactive channel
    for (int i = 0; i < 2; i++) begin
      rampActive = (i == 0);
      channelActive = (i == 0);
      uv(1'b1, 12);
      uv(1'b0, 4);
    end
    rampActive = 1'b0;
    channelActive = 1'b1;
    rdchk(CMD_ST_VOUT, 16'h0000);
    uv(1'b1, 12);
    check({15'h0000, channelEnable}, 16'h0001);
    check({15'h0000, alert}, 16'h0001);
    rdchk(CMD_ST_WORD, 16'h8000);
    uv(1'b0, 12);
    rdchk(CMD_ST_VOUT, 16'h0010);
    clr;
    wr(CMD_ALERT_MASK, 8'h01);
    uv(1'b1, 12);
    check({15'h0000, alert}, 16'h0000);
    rdchk(CMD_ST_VOUT, 16'h0010);
    uv(1'b0, 4);
    wr(CMD_ALERT_MASK, 8'h00);
    clr;
    $display("test ignore and mask finished");
    wr(CMD_UV_RESP, 8'h80);
    uvComparator = 1'b1;
    wait_en(1'b0, 12);
    uv(1'b0, 900);
    check({15'h0000, channelEnable}, 16'h0000);
    wr(CMD_OPERATION, 8'h00);
    wr(CMD_OPERATION, OPERATION_RST);
    wait_en(1'b1, 20);
    rdchk(CMD_ST_VOUT, 16'h0000);
    $display("test shutdown finished");
    // n = 2 ticks: a 300 cycle fault cannot outlast the shortest deglitch
    wr(CMD_UV_RESP, 8'h42);
    uv(1'b1, 300);
    uv(1'b0, 20);
    check({15'h0000, channelEnable}, 16'h0001);
    clr;
    uv(1'b1, 390);
    check({15'h0000, channelEnable}, 16'h0001);
    wait_en(1'b0, 450);
    uv(1'b0, 2);
    channelRunPin = 1'b0;
    cyc(10);
    channelRunPin = 1'b1;
    wait_en(1'b1, 20);
    rdchk(CMD_ST_VOUT, 16'h0000);
    $display("test deglitch finished");
    wr(CMD_UV_RESP, 8'hB8);
    uvComparator = 1'b1;
    wait_en(1'b0, 12);
    wait_en(1'b1, 900);
    check({15'h0000, n > 380}, 16'h0001);
    uv(1'b0, 4);
    wr(CMD_OPERATION, 8'h00);
    wait_en(1'b0, 10);
    wr(CMD_OPERATION, OPERATION_RST);
    wait_en(1'b1, 20);
    clr;
    $display("test retry finished");
    tonMaxExpired = 1'b1;
    cyc(3);
    tonMaxExpired = 1'b0;
    cyc(2);
    rdchk(CMD_ST_WORD, 16'h8001);
    rdchk(CMD_ST_VOUT, 16'h0004);
    check({15'h0000, alert}, 16'h0001);
    check({15'h0000, channelEnable}, 16'h0001);
    // timeout action 80h must shut down and latch
    wr(CMD_TON_RESP, 8'h80);
    tonMaxExpired = 1'b1;
    wait_en(1'b0, 12);
    tonMaxExpired = 1'b0;
    cyc(4);
    check({15'h0000, channelEnable}, 16'h0000);
    clr;
    wait_en(1'b1, 20);
    $display("test turn-on timeout finished");
    tally_and_finish;
  end
endmodule
`default_nettype wire
